// File: otp_port_defs.svh
/*
 * timing counts, field positions and mode codes for the programming port.
 * assumes a 250 MHz reference clock; included by the package and the port.
 */
`ifndef OTP_PORT_DEFS_SVH
`define OTP_PORT_DEFS_SVH

`define ARRAY_BYTES 32768
`define ADDR_W 15
`define LOW_ADDR_W 8
`define HIGH_ADDR_W 7
`define DATA_W 8
`define CLK_PERIOD_NS 4
`define WRITE_STROBE_A_TIME_US 100
`define WRITE_STROBE_A_CYCLES ((`WRITE_STROBE_A_TIME_US * 1000) / `CLK_PERIOD_NS)
`define MODE_RESERVED 2'h0
`define MODE_VERSION 2'h1
`define MODE_LOCK 2'h2
`define MODE_ARRAY 2'h3
`define LOCK_RESET 2'h3
`define LOCK_LSB 0
`define LOCK_MSB 1
`define VERSION_COUNT 2

`endif

// File: otp_port_pkg.sv
/*
 * types shared by the programming port.
 * assumes otp_port_defs.svh is on the include path.
 */
`include "otp_port_defs.svh"

package otp_port_pkg;

    // captured access mode
    typedef enum logic [1:0] {
        ACC_RESERVED = `MODE_RESERVED,
        ACC_VERSION = `MODE_VERSION,
        ACC_LOCK = `MODE_LOCK,
        ACC_ARRAY = `MODE_ARRAY
    } access_mode_t;

    // strobes sampled from the programmer pins
    typedef struct packed {
        logic read;
        logic write;
        logic latch;
        logic select;
        logic fetch;
    } strobe_set_t;

    // port sequencer states
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_IDLE = 4'h2,
        ST_BURN = 4'h4,
        ST_WAIT = 4'h8
    } port_state_t;

endpackage

// File: otp_programming_port.sv
/*
 * programming-mode access port of the 32k byte one-time programmable code
 * array: multiplexed address, data pins, mode select, strobes, burn timer.
 * assumes every programmer pin is asynchronous to i_ref_clk and is
 * synchronised here; the tristate data wire is resolved outside.
 */
`timescale 1ns/100ps

`include "otp_port_defs.svh"

//
// Overview of operation
// - the array holds 32768 bytes, each reached by its own address.
// - one array byte is burned within about 100 microseconds.
// - the port is a passive slave; the programmer sequences every access.
// - mode 00 reserved, 01 version read, 10 lock bits, 11 array byte.
// - the high address bits are latched on the latch enable falling edge.
// - the read strobe gates array, version and lock reads onto data.
// - programming mode is entered only by the mode select sequence.
// - address pins carry bits 0..7 directly and 8..14 via the latch.
// - the write strobe burns array bytes and lock bits; low at entry.
// - data pins are driven on reads and sampled on writes.
//
module otp_programming_port
    import otp_port_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // programmer control pins
    input wire logic i_access_mode_select_lo,
    input wire logic i_access_mode_select_hi,
    input wire logic i_high_address_latch_enable,
    input wire logic i_write_strobe_a_read_strobe_n,
    input wire logic i_write_strobe_a_n,
    input wire logic i_basic_mode_select,
    input wire logic i_program_fetch_strobe,
    input wire logic i_device_reset,
    // address and data pins
    input wire logic [`LOW_ADDR_W-1:0] i_addr_pins,
    input wire logic [`DATA_W-1:0] i_data_pins,
    output logic [`DATA_W-1:0] o_data_pins,
    output logic o_data_oe_n,
    // status
    output logic o_write_strobe_a_mode,
    output logic o_busy
);

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers; active-low strobes reset to their idle high
    localparam int SW = 5 + 2 + `LOW_ADDR_W + `DATA_W;
    localparam logic [SW-1:0] SYNC_IDLE = {2'h3, {(SW-2){1'h0}}};
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] pin_vec;
    assign pin_vec = {i_write_strobe_a_read_strobe_n, i_write_strobe_a_n,
                      i_high_address_latch_enable, i_basic_mode_select,
                      i_program_fetch_strobe, i_access_mode_select_hi,
                      i_access_mode_select_lo, i_addr_pins, i_data_pins};

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
        end else begin
            sync1 <= pin_vec;
            sync2 <= sync1;
        end
    end

    logic [1:0] rst_sync;
    // device reset pin also synchronised
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], i_device_reset};
        end
    end

    strobe_set_t stb;
    logic [1:0] mode_pins;
    logic [`LOW_ADDR_W-1:0] addr_s;
    logic [`DATA_W-1:0] data_s;
    assign stb.read = ~sync2[SW-1];
    assign stb.write = ~sync2[SW-2];
    assign stb.latch = sync2[SW-3];
    assign stb.select = sync2[SW-4];
    assign stb.fetch = sync2[SW-5];
    assign mode_pins = sync2[SW-6 -: 2];
    assign addr_s = sync2[`LOW_ADDR_W+`DATA_W-1 -: `LOW_ADDR_W];
    assign data_s = sync2[`DATA_W-1:0];

    logic latch_d;
    logic write_d;
    logic select_d;
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            latch_d <= 1'b0;
            write_d <= 1'b0;
            select_d <= 1'b0;
        end else begin
            latch_d <= stb.latch;
            write_d <= stb.write;
            select_d <= stb.select;
        end
    end

    logic latch_rise;
    logic latch_fall;
    logic write_rise;
    assign latch_rise = stb.latch & ~latch_d;
    assign latch_fall = ~stb.latch & latch_d;
    assign write_rise = stb.write & ~write_d;

    ////////////////////////////////////////////////////////////////////////
    // mode entry: select rising while reset high, write pin low, fetch low
    port_state_t state;
    logic entry_ok;
    assign entry_ok = rst_sync[1] & stb.write & ~stb.fetch;

    ////////////////////////////////////////////////////////////////////////
    // access mode captured on latch rise, high address on latch fall
    access_mode_t mode;
    logic [`HIGH_ADDR_W-1:0] high_addr;
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            mode <= ACC_RESERVED;
            high_addr <= '0;
        end else begin
            if (latch_rise) begin
                mode <= access_mode_t'(mode_pins);
            end
            if (latch_fall) begin
                high_addr <= addr_s[`HIGH_ADDR_W-1:0];
            end
        end
    end

    logic [`ADDR_W-1:0] addr;
    assign addr = {high_addr, addr_s};

    ////////////////////////////////////////////////////////////////////////
    // storage: array cells start uninitialised and a burn writes the whole byte; only lock bits are cleared by burning
    logic [`DATA_W-1:0] mem [`ARRAY_BYTES];
    logic [`DATA_W-1:0] version [`VERSION_COUNT];
    logic [1:0] lock_bits;
    localparam logic [`DATA_W-1:0] VERSION_0 = 8'hA5; // arbitrary value
    localparam logic [`DATA_W-1:0] VERSION_1 = 8'h01; // arbitrary value
    assign version[0] = VERSION_0;
    assign version[1] = VERSION_1;

    // burn timer sized for the full cycle
    localparam logic [15:0] BURN_CYCLES = 16'(`WRITE_STROBE_A_CYCLES);
    logic [15:0] burn_cnt;
    logic [`ADDR_W-1:0] burn_addr;
    logic [`DATA_W-1:0] burn_data;
    access_mode_t burn_mode;
    logic burn_go;
    logic burn_done;
    assign burn_go = (state == ST_IDLE) & write_rise &
                     (mode == ACC_ARRAY || mode == ACC_LOCK);
    assign burn_done = (state == ST_BURN) && (burn_cnt == 16'h0001);

    // sequencer; leaving reset drops programming mode
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= ST_OFF;
        end else if (!rst_sync[1]) begin
            state <= ST_OFF;
        end else begin
            unique case (state)
                ST_OFF: begin
                    if (entry_ok && stb.select && !select_d) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (burn_go) begin
                        state <= ST_BURN;
                    end
                end
                ST_BURN: begin
                    if (burn_done) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!stb.write) begin
                        state <= ST_IDLE; // one burn per strobe
                    end
                end
            endcase
        end
    end

    // capture burn target, count down the cell cycle
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            burn_cnt <= 16'h0000;
            burn_addr <= '0;
            burn_data <= '0;
            burn_mode <= ACC_RESERVED;
        end else if (burn_go) begin
            burn_cnt <= BURN_CYCLES;
            burn_addr <= addr;
            burn_data <= data_s;
            burn_mode <= mode;
        end else if (state == ST_BURN) begin
            burn_cnt <= burn_cnt - 16'h0001;
        end
    end

    // cell write at the end of the burn; memory left unreset on purpose
    always_ff @(posedge i_ref_clk) begin
        if (burn_done && burn_mode == ACC_ARRAY) begin
            mem[burn_addr] <= burn_data;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            lock_bits <= `LOCK_RESET;
        end else if (burn_done && burn_mode == ACC_LOCK) begin
            lock_bits <= lock_bits & burn_data[`LOCK_MSB:`LOCK_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path: data flop loaded while read strobe active
    logic rd_ok;
    assign rd_ok = (state == ST_IDLE) & stb.read & ~stb.write &
                   (mode != ACC_RESERVED);

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_data_pins <= '0;
            o_data_oe_n <= 1'b1;
        end else begin
            o_data_oe_n <= ~rd_ok;
            if (rd_ok) begin
                unique case (mode)
                    ACC_ARRAY: o_data_pins <= mem[addr];
                    ACC_LOCK: o_data_pins <= {6'h00, lock_bits};
                    ACC_VERSION: o_data_pins <= version[addr[0]];
                    ACC_RESERVED: o_data_pins <= '0;
                endcase
            end
        end
    end

    assign o_write_strobe_a_mode = (state != ST_OFF);
    assign o_busy = (state == ST_BURN);

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_reserved_undriven: assert property (@(posedge i_ref_clk)
        disable iff (i_reset) (mode == ACC_RESERVED) |=> o_data_oe_n)
        else $error("data driven in reserved mode");
    a_read_drives: assert property (@(posedge i_ref_clk)
        disable iff (i_reset) rd_ok |=> !o_data_oe_n)
        else $error("read strobe did not drive data");
    a_no_drive_idle: assert property (@(posedge i_ref_clk)
        disable iff (i_reset) !stb.read |=> o_data_oe_n)
        else $error("data driven without read strobe");
    a_burn_length: assert property (@(posedge i_ref_clk)
        disable iff (i_reset) burn_go |=> (burn_cnt == BURN_CYCLES))
        else $error("burn timer not loaded with full count");
    a_burn_ends: assert property (@(posedge i_ref_clk)
        disable iff (i_reset) burn_done |=> state == ST_WAIT)
        else $error("burn did not finish");
    a_high_latch: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        latch_fall |=> high_addr == $past(addr_s[`HIGH_ADDR_W-1:0]))
        else $error("high address not latched");
    a_mode_capture: assert property (@(posedge i_ref_clk)
        disable iff (i_reset) latch_rise |=> mode == $past(mode_pins))
        else $error("access mode not captured");
    a_entry_needs_reset: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (state == ST_OFF && !entry_ok) |=> state == ST_OFF)
        else $error("entered mode without conditions");
    a_exit_on_reset_low: assert property (@(posedge i_ref_clk)
        disable iff (i_reset) !rst_sync[1] |=> state == ST_OFF)
        else $error("stayed in mode with reset low");
    c_array_burn: cover property (@(posedge i_ref_clk)
        burn_go && mode == ACC_ARRAY);
    c_lock_burn: cover property (@(posedge i_ref_clk)
        burn_go && mode == ACC_LOCK);
    c_version_read: cover property (@(posedge i_ref_clk)
        rd_ok && mode == ACC_VERSION);

endmodule // otp_programming_port

// File: otp_programmer_pins.sv
/*
 * data wire of the programmer side: resolves the shared data byte.
 * assumes the bench decides when the programmer drives the byte.
 */
`timescale 1ns/100ps

`include "otp_port_defs.svh"

module otp_programmer_pins (
    // clock
    input wire logic i_ref_clk,
    // device side of the wire
    input wire logic i_dut_oe_n,
    input wire logic [`DATA_W-1:0] i_dut_data,
    // programmer side of the wire
    input wire logic i_write_strobe_a_drive,
    input wire logic [`DATA_W-1:0] i_write_strobe_a_data,
    // resolved level
    output logic [`DATA_W-1:0] o_wire
);
    logic [`DATA_W-1:0] last = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // undriven wire toggles, so a stale byte can never pass for a read
    always_comb begin
        if (!i_dut_oe_n) begin
            o_wire = i_dut_data;
        end else if (i_write_strobe_a_drive) begin
            o_wire = i_write_strobe_a_data;
        end else begin
            o_wire = ~last;
        end
    end

    // remember the level for the floating pattern
    always_ff @(posedge i_ref_clk) begin
        last <= o_wire;
    end
endmodule // otp_programmer_pins

// File: test_otp_programming_port.sv
/*
 * self-checking bench for the programming port.
 * assumes a 250 MHz clock and the fixed 25000-cycle burn.
 */
`timescale 1ns/100ps

`include "otp_port_defs.svh"

module test_otp_programming_port;
    import otp_port_pkg::*;

    logic clk = 0, rst = 1, mlo = 0, mhi = 0, latch = 0, rd_n = 1;
    logic wr_n = 1, sel = 0, fetch = 0, dev_rst = 1, pdrv = 0;
    logic [7:0] addr = 8'h00, pdat = 8'h00, wire_d, dout;
    logic oe_n, pmode, busy;
    int failures = 0, n_tests = 0;

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard: three burns plus setup fit well inside
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        #400000;
        failures++;
        summarize();
    end

    // device and its far-side wire
    otp_programming_port dut (.i_ref_clk(clk), .i_reset(rst),
        .i_access_mode_select_lo(mlo), .i_access_mode_select_hi(mhi),
        .i_high_address_latch_enable(latch), .i_write_strobe_a_read_strobe_n(rd_n),
        .i_write_strobe_a_n(wr_n), .i_basic_mode_select(sel),
        .i_program_fetch_strobe(fetch), .i_device_reset(dev_rst),
        .i_addr_pins(addr), .i_data_pins(wire_d), .o_data_pins(dout),
        .o_data_oe_n(oe_n), .o_write_strobe_a_mode(pmode), .o_busy(busy));
    otp_programmer_pins write_strobe_a (.i_ref_clk(clk), .i_dut_oe_n(oe_n),
        .i_dut_data(dout), .i_write_strobe_a_drive(pdrv), .i_write_strobe_a_data(pdat),
        .o_wire(wire_d));

    ////////////////////////////////////////////////////////////////////////
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    // mode moves only with latch low, then high address via the latch
    task set_mode(input logic [1:0] m, input logic [14:0] a);
        latch <= 0;
        tick(4);
        {mhi, mlo} <= m;
        tick(4);
        latch <= 1;
        addr <= {1'b0, a[14:8]};
        tick(4);
        latch <= 0;
        tick(4);
        addr <= a[7:0];
        tick(4);
    endtask

    // the read strobe gates the byte onto the wire
    task rd(input string nm, input logic [7:0] e);
        rd_n <= 0;
        tick(5);
        #1 chk("oe_on_read", 0, oe_n);
        chk(nm, e, wire_d);
        tick(1);
        rd_n <= 1;
        tick(5);
        #1 chk("oe_after_read", 1, oe_n);
        tick(1);
    endtask

    // a read is held low through the burn and must stay unanswered
    task burn(input logic [7:0] d);
        int n;
        logic seen;
        n = 0;
        seen = 0;
        pdrv <= 1;
        pdat <= d;
        tick(4);
        wr_n <= 0;
        rd_n <= 0;
        tick(1);
        #1;
        while (busy !== 1'b1 && n < 10) begin
            tick(1);
            #1 n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 30000) begin
            tick(1);
            #1 n++;
            if (oe_n !== 1'b1) seen = 1;
        end
        chk("burn_cycles", `WRITE_STROBE_A_CYCLES, n[15:0]);
        chk("read_in_burn", 0, seen);
        tick(1);
        rd_n <= 1;
        wr_n <= 1;
        pdrv <= 0;
        tick(5);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task t_entry;
        #1 chk("oe_reset", 1, oe_n);
        chk("mode_reset", 0, pmode);
        chk("busy_reset", 0, busy);
        tick(1);
        sel <= 1;
        tick(6);
        #1 chk("entry_refused", 0, pmode);
        tick(1);
        sel <= 0;
        wr_n <= 0;
        tick(6);
        sel <= 1;
        tick(6);
        #1 chk("entry", 1, pmode);
        tick(1);
        wr_n <= 1;
        tick(4);
    endtask

    task t_array;
        set_mode(2'h3, 15'h7FFF);
        burn(8'h5A);
        set_mode(2'h3, 15'h00FF);
        burn(8'hC3);
        rd("array_low", 8'hC3);
        set_mode(2'h3, 15'h7FFF);
        rd("array_top", 8'h5A);
    endtask

    task t_version;
        set_mode(2'h1, 15'h0000);
        rd("version0", 8'hA5);
        set_mode(2'h1, 15'h0001);
        rd("version1", 8'h01);
    endtask

    task t_lock;
        set_mode(2'h2, 15'h0000);
        rd("lock_reset", 8'h03);
        burn(8'h02);
        rd("lock_cleared", 8'h02);
    endtask

    task t_reserved;
        set_mode(2'h0, 15'h7FFF);
        rd_n <= 0;
        tick(5);
        #1 chk("reserved_oe", 1, oe_n);
        tick(1);
        rd_n <= 1;
        wr_n <= 0;
        tick(5);
        #1 chk("reserved_burn", 0, busy);
        tick(1);
        wr_n <= 1;
        tick(4);
    endtask

    task t_leave;
        dev_rst <= 0;
        tick(6);
        #1 chk("leave", 0, pmode);
    endtask

    task summarize;
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // fetch strobe stays low throughout; device reset stays high until t_leave drops it
    initial begin
        tick(4);
        rst <= 0;
        tick(4);
        t_entry();
        t_array();
        t_version();
        t_lock();
        t_reserved();
        t_leave();
        summarize();
    end
endmodule // test_otp_programming_port
